// File: include/scs_params.svh
// Register offsets, field positions, reset values and timing counts for the clock source select
`ifndef SCS_PARAMS_SVH
`define SCS_PARAMS_SVH

// Register byte offsets
`define SCS_OFF_STATUS 12'h000
`define SCS_OFF_CTRL 12'h004
`define SCS_OFF_UNLOCK 12'h008
`define SCS_OFF_DIV 12'h00C
`define SCS_OFF_IRQ_STAT 12'h010
`define SCS_OFF_IRQ_MASK 12'h014
`define SCS_OFF_CONFIG 12'h018

// Status bit positions
`define SCS_ST_PLL 7
`define SCS_ST_LOW_POWER_RC_OSCILLATOR 5
`define SCS_ST_SOSC 4
`define SCS_ST_POSC 2
`define SCS_ST_DIVPLL 1
`define SCS_ST_FRC 0

// Control register fields
`define SCS_CTRL_SEL_LSB 0
`define SCS_CTRL_PLLSEL 4
`define SCS_CTRL_MODE_LSB 8
`define SCS_CTRL_PINFN 12
`define SCS_CTRL_SWITCH 16

// Unlock keys
`define SCS_KEY1 32'hAA99_6655
`define SCS_KEY2 32'h5566_99AA

// Erased default configuration
`define SCS_RST_SEL 3'h7
`define SCS_RST_MODE 2'h0

// Interrupt bit positions
`define SCS_IRQ_DONE 0
`define SCS_IRQ_LOCKERR 1

// Stabilisation time of the ready flags
`define SCS_STABLE_NS 400
`define SCS_CLK_NS 100
`define SCS_STABLE_CYC ((`SCS_STABLE_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)

`endif

// File: include/scs_pkg.sv
// Types for the clock source select block
`default_nettype none
package scs_pkg;
  typedef enum logic [2:0] {
    SCS_SRC_FRCDIV0 = 3'h0,
    SCS_SRC_PLL = 3'h1,
    SCS_SRC_POSC = 3'h2,
    SCS_SRC_RSV3 = 3'h3,
    SCS_SRC_SOSC = 3'h4,
    SCS_SRC_LOW_POWER_RC_OSCILLATOR = 3'h5,
    SCS_SRC_RSV6 = 3'h6,
    SCS_SRC_FAST_RC_POSTSCALED_MODE = 3'h7
  } scs_src_t;
  typedef enum logic [1:0] {
    SCS_MODE_EXT = 2'h0,
    SCS_MODE_RSV1 = 2'h1,
    SCS_MODE_XTAL = 2'h2,
    SCS_MODE_RSV3 = 2'h3
  } scs_mode_t;
  typedef enum {SCS_LK_LOCKED, SCS_LK_KEY1, SCS_LK_OPEN} scs_lock_t;
  typedef enum {SCS_SW_IDLE, SCS_SW_WAIT} scs_sw_t;
endpackage
`default_nettype wire

// File: hdl/scs_clock_select.sv
// System clock source selection, divider, ready status and APB registers
`include "scs_params.svh"
`default_nettype none

// Functional notes
// - Status bit 7 shows PLL locked, whether or not the PLL is enabled, else zero.
// - Status bit 5 shows low-power RC stable, else zero.
// - Status bit 4 shows secondary oscillator stable, else zero.
// - Status bit 2 shows primary oscillator stable, else zero.
// - Status bit 1 shows divided PLL output ready, else zero.
// - Status bit 0 shows fast RC stable, else zero.
// - Status bits 31-8, 6 and 3 read as zero.
// - Control writes are locked until a two-word unlock sequence is written.
// - Source starts from configuration and software may switch it at runtime.
// - Selected clock may be divided by a four-bit divisor, at most 16.
// - Code 111/000 fast RC, 101 LOW_POWER_RC_OSCILLATOR, 100 secondary, 010 primary, 001 PLL.
// - PLL input is primary oscillator when select is 0, fast RC when 1.
// - Primary mode 10 means crystal, 00 means external clock input.
// - Erased configuration selects fast RC with postscaler.
// - Configuration bit gives the free second oscillator pin to bus clock or I/O.
// - No scaling beyond the programmed dividers and multipliers.
// - Divide code 0 passes the clock; code n divides by n plus one.
module scs_clock_select (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire scs_pkg::scs_src_t cfg_source_select_code,
  input wire scs_pkg::scs_mode_t cfg_primary_mode_field,
  input wire logic cfg_pll_input_select,
  input wire logic cfg_osc_pin_function_select,
  input wire logic cfg_erased,
  input wire logic fast_rc_oscillator,
  input wire logic low_power_rc_oscillator,
  input wire logic secondary_osc_clk,
  input wire logic primary_osc_clk,
  input wire logic pll_out_clk,
  input wire logic fast_rc_stable,
  input wire logic low_power_rc_stable,
  input wire logic secondary_osc_stable,
  input wire logic primary_osc_stable,
  input wire logic pll_locked,
  output logic system_clock,
  output logic [2:0] active_source,
  output logic pll_from_fast_rc,
  output logic primary_crystal_en,
  output logic primary_ext_clk_en,
  output logic pll_enable,
  output logic second_oscillator_pin_oe_n,
  output logic second_oscillator_pin_clk_sel,
  output logic irq
);
  import scs_pkg::*;

  // Ready flag of a source code; rdy is {divpll, pll, posc, sosc, low_power_rc_oscillator, frc}
  function automatic logic src_ready(input logic [2:0] code, input logic [5:0] rdy);
    unique case (code)
      3'h1: src_ready = rdy[5] & rdy[4];
      3'h2: src_ready = rdy[3];
      3'h4: src_ready = rdy[2];
      3'h5: src_ready = rdy[1];
      3'h3, 3'h6: src_ready = 1'b0;
      default: src_ready = rdy[0];
    endcase
  endfunction

  // Clock level of a source code; c is {pll, posc, sosc, low_power_rc_oscillator, frc}
  function automatic logic src_clk(input logic [2:0] code, input logic [4:0] c);
    unique case (code)
      3'h1: src_clk = c[4];
      3'h2: src_clk = c[3];
      3'h4: src_clk = c[2];
      3'h5: src_clk = c[1];
      default: src_clk = c[0];
    endcase
  endfunction

  // Synchronisers for asynchronous status and clock levels
  logic [9:0] sync1_ff;
  logic [9:0] sync2_ff;
  wire [9:0] raw_in = {pll_out_clk, primary_osc_clk, secondary_osc_clk, low_power_rc_oscillator,
    fast_rc_oscillator, pll_locked, primary_osc_stable, secondary_osc_stable,
    low_power_rc_stable, fast_rc_stable};
  always_ff @(posedge clk) begin
    sync1_ff <= rst ? 10'h000 : raw_in;
    sync2_ff <= rst ? 10'h000 : sync1_ff;
  end

  // Stability filters: a flag reports ready only after holding steady
  logic [4:0] stable_ff;
  logic [2:0] cnt_ff [5];
  logic [4:0] nxt_stable;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      nxt_stable[i] = sync2_ff[i] && (cnt_ff[i] == 3'(`SCS_STABLE_CYC - 1));
    end
  end
  always_ff @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (rst || !sync2_ff[i]) begin
        cnt_ff[i] <= 3'h0;
      end else if (cnt_ff[i] != 3'(`SCS_STABLE_CYC - 1)) begin
        cnt_ff[i] <= cnt_ff[i] + 3'h1;
      end
      stable_ff[i] <= rst ? 1'b0 : (nxt_stable[i] | (stable_ff[i] & sync2_ff[i]));
    end
  end

  // Registers
  logic [2:0] sel_ff;
  logic [2:0] req_sel_ff;
  logic pllsel_ff;
  logic [1:0] mode_ff;
  logic pinfn_ff;
  logic [3:0] div_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_mask_ff;
  logic cfg_loaded_ff;
  logic divpll_ff;
  scs_lock_t lock_ff;
  scs_sw_t sw_ff;

  // APB decode
  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire hit_status = paddr == `SCS_OFF_STATUS;
  wire hit_ctrl = paddr == `SCS_OFF_CTRL;
  wire hit_unlock = paddr == `SCS_OFF_UNLOCK;
  wire hit_div = paddr == `SCS_OFF_DIV;
  wire hit_istat = paddr == `SCS_OFF_IRQ_STAT;
  wire hit_imask = paddr == `SCS_OFF_IRQ_MASK;
  wire hit_cfg = paddr == `SCS_OFF_CONFIG;
  wire hit_any = hit_status | hit_ctrl | hit_unlock | hit_div | hit_istat | hit_imask | hit_cfg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // Status word: unimplemented bits tie to zero
  wire [5:0] rdy_vec = {divpll_ff, stable_ff[4], stable_ff[3], stable_ff[2], stable_ff[1],
    stable_ff[0]};
  wire [31:0] status_word = {24'h00_0000,
    stable_ff[4],
    1'b0,
    stable_ff[1],
    stable_ff[2],
    1'b0,
    stable_ff[3],
    divpll_ff,
    stable_ff[0]};

  // Unlock sequence and control write gate
  wire ctrl_wr = wr_en && hit_ctrl;
  wire ctrl_ok = ctrl_wr && (lock_ff == SCS_LK_OPEN);
  wire lock_err = ctrl_wr && (lock_ff != SCS_LK_OPEN);
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_ff <= SCS_LK_LOCKED;
    end else if (wr_en && hit_unlock) begin
      unique case (lock_ff)
        SCS_LK_LOCKED: lock_ff <= (pwdata == `SCS_KEY1) ? SCS_LK_KEY1 : SCS_LK_LOCKED;
        SCS_LK_KEY1: lock_ff <= (pwdata == `SCS_KEY2) ? SCS_LK_OPEN : SCS_LK_LOCKED;
        SCS_LK_OPEN: lock_ff <= (pwdata == `SCS_KEY1) ? SCS_LK_KEY1 : SCS_LK_LOCKED;
      endcase
    end else if (ctrl_wr) begin
      lock_ff <= SCS_LK_LOCKED;
    end
  end

  // Switch request: captured, then committed once the target is ready
  wire [2:0] cfg_sel = cfg_erased ? `SCS_RST_SEL : cfg_source_select_code;
  wire req_switch = ctrl_ok && pwdata[`SCS_CTRL_SWITCH];
  wire [2:0] new_sel = pwdata[`SCS_CTRL_SEL_LSB +: 3];
  wire tgt_ready = src_ready(req_sel_ff, rdy_vec);
  wire sw_done = (sw_ff == SCS_SW_WAIT) && tgt_ready;
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_loaded_ff <= 1'b0;
      sel_ff <= `SCS_RST_SEL;
      req_sel_ff <= `SCS_RST_SEL;
      pllsel_ff <= 1'b0;
      mode_ff <= `SCS_RST_MODE;
      pinfn_ff <= 1'b0;
      sw_ff <= SCS_SW_IDLE;
    end else if (!cfg_loaded_ff) begin
      cfg_loaded_ff <= 1'b1;
      sel_ff <= cfg_sel;
      req_sel_ff <= cfg_sel;
      pllsel_ff <= cfg_erased ? 1'b0 : cfg_pll_input_select;
      mode_ff <= cfg_erased ? `SCS_RST_MODE : cfg_primary_mode_field;
      pinfn_ff <= cfg_erased ? 1'b0 : cfg_osc_pin_function_select;
    end else if (req_switch) begin
      req_sel_ff <= new_sel;
      pllsel_ff <= pwdata[`SCS_CTRL_PLLSEL];
      mode_ff <= pwdata[`SCS_CTRL_MODE_LSB +: 2];
      pinfn_ff <= pwdata[`SCS_CTRL_PINFN];
      sw_ff <= SCS_SW_WAIT;
    end else if (sw_done) begin
      sel_ff <= req_sel_ff;
      sw_ff <= SCS_SW_IDLE;
    end
  end

  // Divider and interrupt registers
  always_ff @(posedge clk) begin
    if (rst) begin
      div_ff <= 4'h0;
      irq_mask_ff <= 2'h0;
      irq_stat_ff <= 2'h0;
    end else begin
      if (wr_en && hit_div) begin
        div_ff <= pwdata[3:0];
      end
      if (wr_en && hit_imask) begin
        irq_mask_ff <= pwdata[1:0];
      end
      irq_stat_ff <= (irq_stat_ff & ~((wr_en && hit_istat) ? pwdata[1:0] : 2'h0))
        | {lock_err, sw_done};
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  // Primary mode and PLL feed decode
  wire use_pll = sel_ff == 3'h1 || req_sel_ff == 3'h1;
  wire use_posc = (sel_ff == 3'h2) || (use_pll && !pllsel_ff);
  assign primary_crystal_en = use_posc && mode_ff == 2'h2;
  assign primary_ext_clk_en = use_posc && mode_ff == 2'h0;
  assign pll_enable = use_pll;
  assign pll_from_fast_rc = pllsel_ff;
  assign active_source = sel_ff;

  // Second oscillator pin is free unless crystal mode uses it
  assign second_oscillator_pin_oe_n = primary_crystal_en || !pinfn_ff;
  assign second_oscillator_pin_clk_sel = !primary_crystal_en && pinfn_ff;

  // Divided PLL ready follows lock while the PLL is selected or requested and its input is stable
  always_ff @(posedge clk) begin
    divpll_ff <= rst ? 1'b0 : (stable_ff[4] && use_pll && (pllsel_ff ? stable_ff[0]
      : stable_ff[3]));
  end

  // Clock mux and divider: divide code n gives n plus one
  wire sel_clk = src_clk(sel_ff, sync2_ff[9:5]);
  logic sel_clk_d_ff;
  logic [3:0] div_cnt_ff;
  logic sys_ff;
  wire rise = sel_clk && !sel_clk_d_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_clk_d_ff <= 1'b0;
      div_cnt_ff <= 4'h0;
      sys_ff <= 1'b0;
    end else begin
      sel_clk_d_ff <= sel_clk;
      if (div_ff == 4'h0) begin
        sys_ff <= sel_clk;
      end else if (rise) begin
        div_cnt_ff <= (div_cnt_ff >= div_ff) ? 4'h0 : div_cnt_ff + 4'h1;
        sys_ff <= div_cnt_ff == 4'h0;
      end
    end
  end
  assign system_clock = sys_ff;

  // Read mux
  wire [31:0] ctrl_word = {15'h0000, sw_ff == SCS_SW_WAIT, 3'h0, pinfn_ff, 2'h0, mode_ff,
    3'h0, pllsel_ff, 1'b0, sel_ff};
  wire [31:0] rd_word = hit_status ? status_word :
    hit_ctrl ? ctrl_word :
    hit_unlock ? {30'h0000_0000, lock_ff == SCS_LK_OPEN, lock_ff == SCS_LK_KEY1} :
    hit_div ? {28'h000_0000, div_ff} :
    hit_istat ? {30'h0000_0000, irq_stat_ff} :
    hit_imask ? {30'h0000_0000, irq_mask_ff} :
    hit_cfg ? {27'h000_0000, cfg_erased, cfg_osc_pin_function_select, cfg_source_select_code} :
    32'h0000_0000;
  always_ff @(posedge clk) begin
    prdata <= rst ? 32'h0000_0000 : ((psel && !penable && !pwrite) ? rd_word : prdata);
  end
endmodule
`default_nettype wire

// File: verif/scs_checker.sv
// Port-level assertions for the clock source select block
`default_nettype none
module scs_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic [2:0] active_source,
  input wire logic primary_crystal_en,
  input wire logic primary_ext_clk_en,
  input wire logic second_oscillator_pin_oe_n,
  input wire logic second_oscillator_pin_clk_sel,
  input wire logic irq
);
  import scs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Status reads keep unused bits clear
  property p_rsv;
    psel && penable && !pwrite && paddr == 12'h000
      |-> prdata[31:8] == 0 && !prdata[6] && !prdata[3];
  endproperty
  a_rsv: assert property (p_rsv) else $error("status reserved bit set");
  // Access above the config offset flags an error, status does not
  property p_bad;
    psel && penable && paddr > 12'h018 |-> pslverr;
  endproperty
  a_bad: assert property (p_bad) else $error("no error on unmapped address");
  property p_ok;
    psel && penable && paddr == 12'h000 |-> !pslverr;
  endproperty
  a_ok: assert property (p_ok) else $error("error on status access");
  // Leaving reset shows the fast RC source and no interrupt
  property p_rsrc;
    $fell(rst) |-> active_source == 3'h7;
  endproperty
  a_rsrc: assert property (p_rsrc) else $error("source wrong in reset");
  property p_rirq;
    $fell(rst) |-> !irq;
  endproperty
  a_rirq: assert property (p_rirq) else $error("irq high in reset");
  // Primary modes are exclusive
  property p_mode;
    primary_crystal_en |-> !primary_ext_clk_en;
  endproperty
  a_mode: assert property (p_mode) else $error("both primary modes on");
  // Bus clock output only while the pin is driven
  property p_pin;
    second_oscillator_pin_clk_sel |-> !second_oscillator_pin_oe_n;
  endproperty
  a_pin: assert property (p_pin) else $error("clock out on undriven pin");
  // Reserved codes never become active unless the configuration code is reserved
  property p_src;
    active_source != 3'h3 && active_source != 3'h6;
  endproperty
  a_src: assert property (p_src) else $error("reserved source active");
endmodule
bind scs_clock_select scs_checker chk_u (.clk, .rst, .psel, .penable, .pwrite, .paddr,
  .prdata, .pslverr, .active_source, .primary_crystal_en, .primary_ext_clk_en,
  .second_oscillator_pin_oe_n, .second_oscillator_pin_clk_sel, .irq);
`default_nettype wire

// File: verif/scs_clock_select_tb.sv
// Self-checking bench for the clock source select block
`default_nettype none
module scs_clock_select_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import scs_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, sl;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, system_clock, pll_from_fast_rc, pll_enable, irq;
  logic primary_crystal_en, primary_ext_clk_en;
  logic second_oscillator_pin_oe_n, second_oscillator_pin_clk_sel;
  logic [2:0] active_source;
  scs_src_t cfg_src = SCS_SRC_PLL;
  scs_mode_t cfg_mode = SCS_MODE_EXT;
  logic cfg_pll = 0, cfg_fn = 0, cfg_erased = 1;
  logic [4:0] stb = 5'h00, oc = 5'h00;
  int bad_count = 0, n_tests = 0, hi = 0;
  // Ready inputs per row, status expected with bit 1 masked
  logic [4:0] r_stb [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00};
  logic [31:0] r_exp [6] = '{32'h0000_0001, 32'h0000_0020, 32'h0000_0010, 32'h0000_0004,
    32'h0000_0080, 0};
  // Clock and free-running source levels
  always #50 clk = ~clk;
  always @(posedge clk) oc <= oc + 5'h01;
  scs_clock_select dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cfg_source_select_code(cfg_src), .cfg_primary_mode_field(cfg_mode),
    .cfg_pll_input_select(cfg_pll), .cfg_osc_pin_function_select(cfg_fn), .cfg_erased,
    .fast_rc_oscillator(oc[0]), .low_power_rc_oscillator(oc[1]), .secondary_osc_clk(oc[2]),
    .primary_osc_clk(oc[3]), .pll_out_clk(oc[4]), .fast_rc_stable(stb[0]),
    .low_power_rc_stable(stb[1]), .secondary_osc_stable(stb[2]), .primary_osc_stable(stb[3]),
    .pll_locked(stb[4]), .system_clock, .active_source, .pll_from_fast_rc, .primary_crystal_en,
    .primary_ext_clk_en, .pll_enable, .second_oscillator_pin_oe_n,
    .second_oscillator_pin_clk_sel, .irq);
  // One APB transfer, entered just after a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      bad_count++;
    end
  endtask
  // Unlock, then request a switch
  task sw(input logic [31:0] c);
    apb(1, 12'h008, 32'hAA99_6655);
    apb(1, 12'h008, 32'h5566_99AA);
    apb(1, 12'h004, c);
  endtask
  task waitsrc(input logic [2:0] s);
    for (int k = 0; k < 60 && active_source !== s; k++) @(posedge clk);
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    results();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("active_source", 32'h7, 32'(active_source));
    chk("irq", 0, 32'(irq));
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      stb <= r_stb[i];
      repeat (10) @(posedge clk);
      apb(0, 12'h000, 0);
      chk("status", r_exp[i], rd & 32'hFFFF_FFFD);
    end
    $display("test status rows done");
    stb <= 5'h02;
    apb(1, 12'h004, 32'h0001_1005);
    apb(0, 12'h010, 0);
    chk("lock_err", 32'h2, rd & 32'h2);
    apb(1, 12'h014, 32'h2);
    chk("irq_on", 1, 32'(irq));
    apb(1, 12'h010, 32'h2);
    chk("irq_off", 0, 32'(irq));
    sw(32'h0001_1005);
    waitsrc(3'h5);
    chk("switch", 32'h5, 32'(active_source));
    chk("pin_clk_sel", 1, 32'(second_oscillator_pin_clk_sel));
    apb(0, 12'h010, 0);
    chk("done", 1, rd & 1);
    $display("test unlock switch done");
    sw(32'h0001_1004);
    repeat (20) @(posedge clk);
    chk("held", 32'h5, 32'(active_source));
    stb <= 5'h06;
    waitsrc(3'h4);
    chk("late_switch", 32'h4, 32'(active_source));
    apb(1, 12'h00C, 32'hF);
    apb(0, 12'h00C, 0);
    chk("div", 32'hF, rd);
    repeat (128) @(posedge clk);
    hi = 0;
    repeat (256) begin
      @(posedge clk);
      if (system_clock === 1'b1) hi++;
    end
    chk("system_clock_high", 32'd16, 32'(hi));
    apb(0, 12'h01C, 0);
    chk("unmapped_err", 1, 32'(sl));
    chk("unmapped_rd", 0, rd);
    $display("test held switch and divider done");
    cfg_erased <= 1'b0;
    cfg_src <= SCS_SRC_POSC;
    cfg_mode <= SCS_MODE_XTAL;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("cfg_source", 32'h2, 32'(active_source));
    chk("crystal_en", 1, 32'(primary_crystal_en));
    chk("ext_en", 0, 32'(primary_ext_clk_en));
    chk("pin_oe_n", 1, 32'(second_oscillator_pin_oe_n));
    chk("pll_off", 0, 32'(pll_enable));
    cfg_src <= SCS_SRC_PLL;
    cfg_pll <= 1'b1;
    stb <= 5'h11;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (12) @(posedge clk);
    apb(0, 12'h000, 0);
    chk("pll_status", 32'h0000_0083, rd);
    chk("pll_src", 32'h1, 32'(active_source));
    chk("pll_fast_rc", 1, 32'(pll_from_fast_rc));
    chk("pll_on", 1, 32'(pll_enable));
    chk("pll_no_xtal", 0, 32'(primary_crystal_en));
    $display("test configured boot done");
    results();
  end
endmodule
`default_nettype wire
